/* File: mss_consts.vh */
// Purpose: Constants for the motion status and signals reporting block
// Assumes: Included once per compilation unit
// Notes: Command codes, status, signals and trajectory bit positions, busy count, narrow reset value
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
`define MSS_CMD_BEGIN_MOTION 8'h01
`define MSS_CMD_NARROW_OUT 8'h05
`define MSS_CMD_WIDE_OUT 8'h06
`define MSS_CMD_READ_DESIRED 8'h08
`define MSS_CMD_READ_INDEX 8'h09
`define MSS_CMD_READ_ACTUAL 8'h0a
`define MSS_CMD_READ_SIGNALS 8'h0c
`define MSS_CMD_FILTER_UPDATE 8'h04
`define MSS_CMD_ARM_INDEX 8'h03
`define MSS_CMD_CLEAR_IRQ 8'h1d
`define MSS_CMD_LOAD_TRAJ 8'h1f
`define MSS_CMD_ERR_STOP 8'h1a
`define MSS_CMD_ERR_IRQ 8'h1b
`define MSS_CMD_LOAD_MASK 8'h1c
`define MSS_ST_BUSY 0
`define MSS_ST_CMD_ERR 1
`define MSS_ST_TRAJ_DONE 2
`define MSS_ST_INDEX 3
`define MSS_SG_ARM 0
`define MSS_SG_NARROW 8
`define MSS_SG_STOP_ERR 9
`define MSS_SG_ON_TARGET 10
`define MSS_SG_VEL_MODE 11
`define MSS_SG_FWD 12
`define MSS_SG_UDF 13
`define MSS_SG_ACCEL 14
`define MSS_SG_HOST_IRQ 15
`define MSS_TRJ_ACCEL_BIT 5
`define MSS_TRJ_VEL_BIT 11
`define MSS_TRJ_FWD_BIT 12
`define MSS_BUSY_CYCLES 4'h3
`define MSS_NARROW_RESET 1'b1
`endif

/* File: mss_status_reporter.v */
// Purpose: Status byte, signals word, host interrupt and position readback
// Assumes: Host strobes synchronous to core_clk_in; one byte per strobe cycle
// Notes: Write strobes take data on the cycle they are seen
`default_nettype none
`include "mss_consts.vh"

module mss_status_reporter #(
    parameter BUSY_CYCLES = `MSS_BUSY_CYCLES
) (
    input wire core_clk_in,
    input wire rst_b_in,
    input wire cs_n_in,
    input wire port_select_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    input wire [7:0] data_in,
    input wire index_pulse_in,
    input wire sample_tick_in,
    input wire move_done_in,
    input wire motor_off_in,
    input wire breakpoint_in,
    input wire pos_error_in,
    input wire wraparound_in,
    input wire [31:0] desired_pos_in,
    input wire [31:0] actual_pos_in,
    output reg [7:0] data_out,
    output reg data_oe_n_out,
    output reg host_irq_out,
    output reg [7:0] status_out,
    output reg [15:0] signals_out,
    output reg [31:0] index_pos_out
);

localparam ST_IDLE = 2'd0;
localparam ST_CMD_DATA = 2'd1;
localparam ST_REPLY = 2'd2;

////////////////////////////////////////////////////////////////////////////////
// Host strobe decode
wire sel = ~cs_n_in;
wire rd_stat = sel & ~port_select_n_in & ~rd_n_in;
wire wr_cmd = sel & ~port_select_n_in & ~wr_n_in;
wire rd_data = sel & port_select_n_in & ~rd_n_in;
wire wr_data = sel & port_select_n_in & ~wr_n_in;

reg [1:0] state_q;
reg [3:0] busy_cnt_q;
reg [2:0] bytes_left_q;
reg [31:0] reply_q;
reg [7:0] cmd_q;
reg wr_byte_q;
reg [15:0] traj_word_q;
reg [7:0] mask_q;
reg cmd_err_q;
reg index_q;
reg done_ack_q;
reg bp_q;
reg perr_q;
reg wrap_q;
reg arm_q;
reg narrow_q;
reg stop_err_q;
reg on_tgt_q;
reg vel_q;
reg fwd_q;
reg udf_q;
reg accel_q;
reg irq_q;
reg vel_pend_q;
reg fwd_pend_q;
reg [7:0] port_buf_q;

// Busy load value; a wider override keeps only the counter's bits
localparam [3:0] BUSY_LOAD = BUSY_CYCLES[3:0];

wire busy = (busy_cnt_q != 4'h0);
wire traj_done = motor_off_in | on_tgt_q;
// Completion shows the OR until acknowledged; it returns once the OR drops and rises again
wire traj_flag = traj_done & ~done_ack_q;
wire [7:0] status_w = {motor_off_in, bp_q, perr_q, wrap_q, index_q, traj_flag, cmd_err_q,
    busy};
wire [15:0] signals_w = {irq_q, accel_q, udf_q, fwd_q, vel_q, on_tgt_q, stop_err_q, narrow_q,
    status_w[7:1], arm_q};

// Accepted strobes; all ignored while busy
wire cmd_go = wr_cmd & ~busy;
wire wdat_go = wr_data & ~busy;
wire rdat_go = rd_data & ~busy;
wire is_read_cmd = (data_in == `MSS_CMD_READ_SIGNALS) | (data_in == `MSS_CMD_READ_INDEX) |
    (data_in == `MSS_CMD_READ_DESIRED) | (data_in == `MSS_CMD_READ_ACTUAL);
wire index_hit = arm_q & index_pulse_in;
wire begin_go = cmd_go & (data_in == `MSS_CMD_BEGIN_MOTION);
wire clr_go = cmd_go & (data_in == `MSS_CMD_CLEAR_IRQ);
wire bad_rd = rdat_go & (state_q != ST_REPLY);
wire bad_wr = wdat_go & (state_q != ST_CMD_DATA);

////////////////////////////////////////////////////////////////////////////////
// Interrupt conditions, ordered as status bits 6 down to 1
wire bp_in_w = breakpoint_in;
wire perr_in_w = pos_error_in;
wire wrap_in_w = wraparound_in;
wire done_ev = move_done_in;
wire [5:0] events = {bp_in_w, perr_in_w, wrap_in_w, index_hit, done_ev, bad_rd | bad_wr};
// Mask bits 6 to 1 line up with the status flags they enable
wire irq_ev = |(events & mask_q[6:1]);

////////////////////////////////////////////////////////////////////////////////
// Command and reply sequencing
always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        state_q <= ST_IDLE;
        busy_cnt_q <= 4'h0;
        bytes_left_q <= 3'd0;
        reply_q <= 32'h0;
        cmd_q <= 8'h0;
        wr_byte_q <= 1'b0;
        traj_word_q <= 16'h0;
        mask_q <= 8'h0;
        port_buf_q <= 8'h0;
    end else begin
        if (busy) begin
            busy_cnt_q <= busy_cnt_q - 4'h1;
        end
        if (cmd_go) begin
            cmd_q <= data_in;
            wr_byte_q <= 1'b0;
            // Commands and in-sequence data bytes start a busy run; status reads never wait
            busy_cnt_q <= BUSY_LOAD;
            if (is_read_cmd) begin
                state_q <= ST_REPLY;
                // Reply word is sampled now and leaves MSB first
                case (data_in)
                    `MSS_CMD_READ_SIGNALS: begin
                        reply_q <= {signals_w, 16'h0};
                        bytes_left_q <= 3'd2;
                    end
                    `MSS_CMD_READ_INDEX: begin
                        reply_q <= index_pos_out;
                        bytes_left_q <= 3'd4;
                    end
                    `MSS_CMD_READ_DESIRED: begin
                        reply_q <= desired_pos_in;
                        bytes_left_q <= 3'd4;
                    end
                    default: begin
                        reply_q <= actual_pos_in;
                        bytes_left_q <= 3'd4;
                    end
                endcase
            end else if ((data_in == `MSS_CMD_LOAD_TRAJ) || (data_in == `MSS_CMD_LOAD_MASK)) begin
                state_q <= ST_CMD_DATA;
            end else begin
                state_q <= ST_IDLE;
            end
        end else if (rdat_go && state_q == ST_REPLY) begin
            port_buf_q <= reply_q[31:24];
            reply_q <= {reply_q[23:0], 8'h0};
            bytes_left_q <= bytes_left_q - 3'd1;
            busy_cnt_q <= BUSY_LOAD;
            if (bytes_left_q == 3'd1) begin
                state_q <= ST_IDLE;
            end
        end else if (wdat_go && state_q == ST_CMD_DATA) begin
            port_buf_q <= data_in;
            busy_cnt_q <= BUSY_LOAD;
            wr_byte_q <= ~wr_byte_q;
            if (!wr_byte_q) begin
                traj_word_q[15:8] <= data_in;
            end else begin
                traj_word_q[7:0] <= data_in;
                if (cmd_q == `MSS_CMD_LOAD_MASK) begin
                    mask_q <= data_in;
                end
                state_q <= ST_IDLE;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status and signals flags
always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        cmd_err_q <= 1'b0;
        index_q <= 1'b0;
        done_ack_q <= 1'b0;
        bp_q <= 1'b0;
        perr_q <= 1'b0;
        wrap_q <= 1'b0;
        arm_q <= 1'b0;
        narrow_q <= `MSS_NARROW_RESET;
        stop_err_q <= 1'b0;
        on_tgt_q <= 1'b0;
        vel_q <= 1'b0;
        fwd_q <= 1'b0;
        udf_q <= 1'b0;
        accel_q <= 1'b0;
        irq_q <= 1'b0;
        vel_pend_q <= 1'b0;
        fwd_pend_q <= 1'b0;
        index_pos_out <= 32'h0;
    end else begin
        // Sticky flags: a set in the clear cycle wins
        cmd_err_q <= (cmd_err_q & ~clr_go) | bad_rd | bad_wr;
        index_q <= (index_q & ~clr_go) | index_hit;
        bp_q <= (bp_q & ~clr_go) | breakpoint_in;
        perr_q <= (perr_q & ~clr_go) | pos_error_in;
        wrap_q <= (wrap_q & ~clr_go) | wraparound_in;
        irq_q <= (irq_q & ~clr_go) | irq_ev;
        if (index_hit) begin
            index_pos_out <= actual_pos_in;
        end
        if (cmd_go && data_in == `MSS_CMD_ARM_INDEX) begin
            arm_q <= 1'b1;
        end else if (index_pulse_in) begin
            arm_q <= 1'b0;
        end
        if (cmd_go && data_in == `MSS_CMD_NARROW_OUT) begin
            narrow_q <= 1'b1;
        end else if (cmd_go && data_in == `MSS_CMD_WIDE_OUT) begin
            narrow_q <= 1'b0;
        end
        if (cmd_go && data_in == `MSS_CMD_ERR_STOP) begin
            stop_err_q <= 1'b1;
        end else if (cmd_go && data_in == `MSS_CMD_ERR_IRQ) begin
            stop_err_q <= 1'b0;
        end
        if (cmd_go && data_in == `MSS_CMD_FILTER_UPDATE) begin
            udf_q <= 1'b1;
        end else if (sample_tick_in) begin
            udf_q <= 1'b0;
        end
        // Second byte of trajectory word latches pending mode bits
        if (wdat_go && state_q == ST_CMD_DATA && wr_byte_q && cmd_q == `MSS_CMD_LOAD_TRAJ) begin
            vel_pend_q <= traj_word_q[`MSS_TRJ_VEL_BIT];
            fwd_pend_q <= traj_word_q[`MSS_TRJ_FWD_BIT];
            if (data_in[`MSS_TRJ_ACCEL_BIT]) begin
                accel_q <= 1'b1;
            end
        end else if (begin_go) begin
            accel_q <= 1'b0;
        end
        if (begin_go) begin
            vel_q <= vel_pend_q;
            fwd_q <= fwd_pend_q;
            on_tgt_q <= 1'b0;
        end else if (move_done_in) begin
            on_tgt_q <= 1'b1;
        end
        // Acknowledge by clear-interrupts; dropping the completion OR re-arms the flag
        done_ack_q <= traj_done & (done_ack_q | clr_go);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs
always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        data_out <= 8'h0;
        data_oe_n_out <= 1'b1;
        host_irq_out <= 1'b0;
        status_out <= 8'h0;
        signals_out <= 16'h0;
    end else begin
        data_oe_n_out <= ~(rd_stat | rd_data);
        if (rd_stat) begin
            data_out <= status_w;
        end else if (rdat_go && state_q == ST_REPLY) begin
            data_out <= reply_q[31:24];
        end else if (rd_data) begin
            data_out <= port_buf_q;
        end
        host_irq_out <= (irq_q & ~clr_go) | irq_ev;
        status_out <= status_w;
        signals_out <= signals_w;
    end
end

endmodule // mss_status_reporter
`default_nettype wire

/* File: mss_status_asserts.sv */
// Purpose: Port checks for the status reporter
// Assumes: Bound to mss_status_reporter
// Notes: Status and signals mirrors share one lag
`default_nettype none
module mss_status_asserts #(
    parameter int BUSY_CYCLES = 3
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic cs_n_in,
    input wire logic port_select_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic index_pulse_in,
    input wire logic sample_tick_in,
    input wire logic data_oe_n_out,
    input wire logic host_irq_out,
    input wire logic [7:0] status_out,
    input wire logic [15:0] signals_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] run_q;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // Length of the current busy run
    always @(posedge core_clk_in) begin
        run_q <= status_out[0] ? run_q + 4'h1 : 4'h0;
    end
    ////////////////////////////////////////
    AST_OE_READ: assert property (1'b1 |=> data_oe_n_out == $past(cs_n_in | rd_n_in))
        else $error("bus enable wrong");
    AST_MIRROR: assert property (status_out[7:1] == signals_out[7:1])
        else $error("status mirror wrong");
    AST_BUSY_CMD: assert property (!cs_n_in && !port_select_n_in && !wr_n_in
        && !status_out[0] |-> ##[1:3] status_out[0]) else $error("no busy after command");
    AST_BUSY_RUN: assert property (run_q <= BUSY_CYCLES)
        else $error("busy too long");
    AST_IRQ_SIG: assert property (host_irq_out |-> ##[0:1] signals_out[15])
        else $error("irq not in signals");
    AST_INDEX: assert property (index_pulse_in && signals_out[0]
        |-> ##[1:3] (status_out[3] && !signals_out[0])) else $error("index not taken");
    AST_UDF_CLR: assert property (sample_tick_in |-> ##[1:2] !signals_out[13])
        else $error("update flag stays");
    AST_NARROW_RST: assert property ($rose(rst_b_in) |-> ##[1:2] signals_out[8])
        else $error("narrow flag not set");
    cover property (host_irq_out);
    cover property ($rose(status_out[3]));
    cover property ($rose(signals_out[10]));
endmodule // mss_status_asserts
`default_nettype wire

/* File: mss_host_model.sv */
// Purpose: Host processor on the 8-bit command/data port
// Assumes: One strobe cycle per byte, reply one cycle later
// Notes: Data line shows the inverse of the last byte once released
`default_nettype none
module mss_host_model (
    input wire logic clk_in,
    input wire logic [7:0] q_in,
    output logic cs_n_out,
    output logic ps_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [7:0] d_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cs_n_out, ps_n_out, rd_n_out, wr_n_out} = 4'hf;
        d_out = 8'h00;
    end
    task automatic xfer(input logic ps, input logic rd, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        {cs_n_out, ps_n_out, rd_n_out, wr_n_out} <= {1'b0, ps, !rd, rd};
        d_out <= d;
        @(posedge clk_in);
        {cs_n_out, rd_n_out, wr_n_out} <= 3'h7;
        d_out <= ~d;
        @(posedge clk_in);
        #1 q = q_in;
    endtask
    task automatic ready();
        logic [7:0] s;
        s = 8'hff;
        for (int i = 0; i < 40 && s[0]; i++) begin
            xfer(1'b0, 1'b1, 8'h00, s);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        logic [7:0] q;
        ready();
        xfer(1'b0, 1'b0, c, q);
        ready();
    endtask
    task automatic rdb(output logic [7:0] q);
        ready();
        xfer(1'b1, 1'b1, 8'h00, q);
    endtask
    task automatic wrb(input logic [7:0] d);
        logic [7:0] q;
        ready();
        xfer(1'b1, 1'b0, d, q);
    endtask
endmodule // mss_host_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the status reporter
// Assumes: Host model drives the port, bench drives motion events
// Notes: Motion event inputs other than motor off are pulsed for one cycle by the bench
`default_nettype none
`define CHK(nm, ex, got) \
    compares++; \
    if ((got) !== (ex)) begin \
        n_errors++; \
        $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, moff;
    logic [5:0] ev;
    logic [31:0] dpos, apos, w;
    logic [7:0] b;
    wire logic cs_n, ps_n, rd_n, wr_n, irq, oe_n;
    wire logic [7:0] wd, rdd, st;
    wire logic [15:0] sg;
    wire logic [31:0] ipos;
    int n_errors = 0;
    int compares = 0;
    mss_status_reporter #(.BUSY_CYCLES(4'h3)) dut (
        .core_clk_in(clk), .rst_b_in(rst_b), .cs_n_in(cs_n), .port_select_n_in(ps_n),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(wd), .index_pulse_in(ev[0]),
        .sample_tick_in(ev[2]), .move_done_in(ev[1]), .motor_off_in(moff),
        .breakpoint_in(ev[3]), .pos_error_in(ev[4]), .wraparound_in(ev[5]),
        .desired_pos_in(dpos), .actual_pos_in(apos), .data_out(rdd), .data_oe_n_out(oe_n),
        .host_irq_out(irq), .status_out(st), .signals_out(sg), .index_pos_out(ipos));
    mss_host_model host (.clk_in(clk), .q_in(rdd), .cs_n_out(cs_n), .ps_n_out(ps_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .d_out(wd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 6'h01 << k;
        @(posedge clk);
        ev <= 6'h00;
        repeat (3) @(posedge clk);
    endtask
    task automatic rd4(input logic [7:0] c, output logic [31:0] v);
        host.cmd(c);
        for (int k = 0; k < 4; k++) begin
            host.rdb(b);
            v = {v[23:0], b};
        end
    endtask
    task automatic t_sig();
        `CHK("narrow", 1'b1, sg[8])
        host.cmd(8'h0c);
        host.rdb(b);
        `CHK("sig_hi", 8'h01, b)
        host.rdb(b);
        `CHK("sig_lo", 8'h00, b)
        host.rdb(b);
        host.ready();
        `CHK("err_irq", 2'b10, {st[1], irq})
        host.cmd(8'h1d);
        `CHK("err_clr", 1'b0, st[1])
        $display("test signals done");
    endtask
    task automatic t_busy();
        host.ready();
        host.xfer(1'b0, 1'b0, 8'h0c, b);
        host.xfer(1'b0, 1'b0, 8'h06, b);
        host.rdb(b);
        `CHK("busy_wr", 8'h01, b)
        host.xfer(1'b1, 1'b1, 8'h00, b);
        `CHK("busy_rd", 8'h01, b)
        host.rdb(b);
        `CHK("next_byte", 8'h00, b)
        `CHK("busy_err", 1'b0, st[1])
        host.cmd(8'h06);
        `CHK("wide", 1'b0, sg[8])
        host.cmd(8'h05);
        `CHK("narrow_cmd", 1'b1, sg[8])
        $display("test busy done");
    endtask
    task automatic t_pos();
        @(posedge clk);
        apos <= 32'h3abc1234;
        dpos <= 32'hc0000007;
        rd4(8'h0a, w);
        `CHK("actual", 32'h3abc1234, w)
        rd4(8'h08, w);
        `CHK("desired", 32'hc0000007, w)
        $display("test positions done");
    endtask
    task automatic t_idx();
        host.cmd(8'h03);
        `CHK("arm", 2'b01, {st[3], sg[0]})
        @(posedge clk);
        apos <= 32'h0000a5a5;
        pulse(0);
        `CHK("idx_flag", 2'b10, {st[3], sg[0]})
        `CHK("idx_reg", 32'h0000a5a5, ipos)
        rd4(8'h09, w);
        `CHK("idx_pos", 32'h0000a5a5, w)
        host.cmd(8'h1d);
        `CHK("idx_clr", 1'b0, st[3])
        $display("test index done");
    endtask
    task automatic t_irq();
        host.cmd(8'h1c);
        host.wrb(8'h00);
        host.wrb(8'h02);
        host.cmd(8'h0c);
        host.wrb(8'h55);
        host.ready();
        `CHK("irq_on", 3'b111, {irq, sg[15], st[1]})
        host.cmd(8'h1d);
        `CHK("irq_off", 2'b00, {irq, sg[15]})
        $display("test interrupt done");
    endtask
    task automatic t_traj();
        host.cmd(8'h1f);
        host.wrb(8'h18);
        host.wrb(8'h20);
        host.ready();
        `CHK("loaded", 5'b10000, sg[14:10])
        host.cmd(8'h01);
        `CHK("started", 5'b00110, sg[14:10])
        pulse(1);
        `CHK("on_target", 2'b11, {sg[10], st[2]})
        host.cmd(8'h1d);
        `CHK("done_ack", 2'b10, {sg[10], st[2]})
        host.cmd(8'h04);
        `CHK("udf_set", 1'b1, sg[13])
        pulse(2);
        `CHK("udf_clr", 1'b0, sg[13])
        host.cmd(8'h1a);
        `CHK("stop_err", 1'b1, sg[9])
        host.cmd(8'h1b);
        `CHK("irq_err", 1'b0, sg[9])
        $display("test trajectory done");
    endtask
    task automatic t_evt();
        host.cmd(8'h01);
        `CHK("ontgt_clr", 2'b00, {sg[10], st[2]})
        for (int k = 3; k < 6; k++) begin
            pulse(k);
        end
        `CHK("evt_flags", 3'b111, st[6:4])
        `CHK("evt_mirror", 3'b111, sg[6:4])
        `CHK("evt_masked", 1'b0, irq)
        @(posedge clk);
        moff <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("motor_off", 3'b111, {st[7], sg[7], st[2]})
        host.cmd(8'h1d);
        `CHK("evt_clr", 5'b10000, st[7:3])
        @(posedge clk);
        moff <= 1'b0;
        $display("test events done");
    endtask
    task automatic t_rst();
        host.cmd(8'h06);
        `CHK("pre_rst", 1'b0, sg[8])
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("in_rst", 18'h20000, {oe_n, irq, sg})
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("post_rst", 16'h0100, sg)
        `CHK("post_rst_idx", 32'h0, ipos)
        $display("test reset done");
    endtask
    task automatic close_out();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        {rst_b, moff} = 2'b00;
        ev = 6'h00;
        dpos = 32'h0;
        apos = 32'h0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_sig();
        t_busy();
        t_pos();
        t_idx();
        t_irq();
        t_traj();
        t_evt();
        t_rst();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule // testbench
bind mss_status_reporter mss_status_asserts #(.BUSY_CYCLES(3)) u_chk (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .cs_n_in(cs_n_in),
    .port_select_n_in(port_select_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
    .index_pulse_in(index_pulse_in), .sample_tick_in(sample_tick_in),
    .data_oe_n_out(data_oe_n_out), .host_irq_out(host_irq_out),
    .status_out(status_out), .signals_out(signals_out));
`default_nettype wire
